// [verilog/pibk_pkg.sv]
// Package with the register map and field layout of the interrupt bank.
package pibk_pkg;

  localparam int BYTE_W  = 8;
  localparam int DATA_W  = 32;
  localparam int ADDR_W  = 8;
  localparam int NUM_EN  = 6;
  localparam int CMP_N   = 3;

  localparam logic [ADDR_W-1:0] OFF_FLAG6   = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_EN1     = 8'h04;
  localparam logic [ADDR_W-1:0] REG_STRIDE  = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_CTRL    = 8'h1C;
  localparam logic [ADDR_W-1:0] OFF_PRIO_LO = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_PRIO_HI = 8'h24;
  localparam logic [ADDR_W-1:0] OFF_ISTAT   = 8'h28;
  localparam logic [ADDR_W-1:0] OFF_IMASK   = 8'h2C;

  localparam int FLAG6_RX4     = 7;
  localparam int FLAG6_TX4     = 6;
  localparam int FLAG6_RX3     = 5;
  localparam int FLAG6_TX3     = 4;
  localparam int FLAG6_UNUSED  = 3;
  localparam int FLAG6_CMP_LSB = 0;

  localparam logic [BYTE_W-1:0] FLAG6_IMPL = 8'hF7;

  // Enable register one sits in the lowest byte.
  localparam logic [NUM_EN-1:0][BYTE_W-1:0] EN_IMPL =
    {8'hF7, 8'h77, 8'hFF, 8'hFF, 8'hFF, 8'hFF};

  localparam int CTRL_GROUP_EN = 0;
  localparam int CTRL_PRIO_EN  = 1;
  localparam int CTRL_W        = 2;

  localparam int EXT_SRC  = 40;
  localparam int NUM_SRC  = EXT_SRC + BYTE_W;
  localparam int PRIO_HI_W = NUM_SRC - DATA_W;

  localparam logic [BYTE_W-1:0]    BYTE_RST  = 8'h00;
  localparam logic [CTRL_W-1:0]    CTRL_RST  = 2'h0;
  localparam logic [DATA_W-1:0]    WORD_ZERO = 32'h0000_0000;
  localparam logic [DATA_W-1:0]    PRIO_LO_RST = 32'hFFFF_FFFF;
  localparam logic [PRIO_HI_W-1:0] PRIO_HI_RST = 16'hFFFF;

endpackage

// [verilog/pibk_bank.sv]
// Peripheral interrupt flag six, enables one to six and core request logic.
`timescale 1ns/1ps

// Contract
// - Serial4 receive flag follows buffer, clears on read
// - Serial4 transmit flag follows empty, clears on write
// - Serial3 receive flag follows buffer, clears on read
// - Serial3 transmit flag follows empty, clears on write
// - Flag six bit three reads zero always
// - Comparator events set sticky flags two to zero
// - Six peripheral enable registers are provided
// - Without priority, group enable gates all requests
// - Enable one passes source, zero blocks it
// - Enable one layout: parallel slave to timer1
// - Enable two layout: oscillator fail to timer3
// - Enable three layout: timer5 gate to clock
// - Enable four layout: capcomp ten to enhanced three
// - Comparator flag and enable bits readable, writable, reset zero
// - Priority on: priority bit picks high or low
module pibk_bank #(
  parameter int EXT_SRC = pibk_pkg::EXT_SRC
) (
  input  wire logic                            pclk,
  input  wire logic                            presetn,
  input  wire logic                            ce,
  input  wire logic                            psel,
  input  wire logic                            penable,
  input  wire logic                            pwrite,
  input  wire logic [pibk_pkg::ADDR_W-1:0]     paddr,
  input  wire logic [pibk_pkg::DATA_W-1:0]     pwdata,
  output logic      [pibk_pkg::DATA_W-1:0]     prdata,
  output logic                                 pready,
  output logic                                 pslverr,
  input  wire logic [EXT_SRC-1:0]              ext_flags,
  input  wire logic                            serial4_rx_full,
  input  wire logic                            serial4_rx_data_reg_rd,
  input  wire logic                            serial4_tx_empty,
  input  wire logic                            serial4_tx_data_reg_wr,
  input  wire logic                            serial3_rx_full,
  input  wire logic                            serial3_rx_data_reg_rd,
  input  wire logic                            serial3_tx_empty,
  input  wire logic                            serial3_tx_data_reg_wr,
  input  wire logic [pibk_pkg::CMP_N-1:0]      comparator_event,
  output logic                                 core_irq_high,
  output logic                                 core_irq_low,
  output logic                                 bank_irq
);

  localparam int BW  = pibk_pkg::BYTE_W;
  localparam int DW  = pibk_pkg::DATA_W;
  localparam int NE  = pibk_pkg::NUM_EN;
  localparam int NS  = EXT_SRC + BW;
  localparam int PHW = NS - DW;

  logic [BW-1:0]         flag6_q;
  logic [BW-1:0]         flag6_d;
  logic [NE-1:0][BW-1:0] en_q;
  logic [NE-1:0][BW-1:0] en_d;
  logic [pibk_pkg::CTRL_W-1:0] ctrl_q;
  logic [pibk_pkg::CTRL_W-1:0] ctrl_d;
  logic [DW-1:0]         prio_lo_q;
  logic [DW-1:0]         prio_lo_d;
  logic [PHW-1:0]        prio_hi_q;
  logic [PHW-1:0]        prio_hi_d;
  logic [BW-1:0]         istat_q;
  logic [BW-1:0]         istat_d;
  logic [BW-1:0]         imask_q;
  logic [BW-1:0]         imask_d;
  logic                  pready_q;
  logic                  pslverr_q;
  logic [DW-1:0]         prdata_q;
  logic                  irq_high_q;
  logic                  irq_low_q;
  logic                  bank_irq_q;

  // Bus decode. One wait state lets read data come from a flip-flop.
  wire access    = psel & penable;
  wire answer    = access & ~pready_q;
  wire wr_en     = access & pready_q & pwrite;
  wire sel_flag6 = paddr == pibk_pkg::OFF_FLAG6;
  wire sel_ctrl  = paddr == pibk_pkg::OFF_CTRL;
  wire sel_plo   = paddr == pibk_pkg::OFF_PRIO_LO;
  wire sel_phi   = paddr == pibk_pkg::OFF_PRIO_HI;
  wire sel_istat = paddr == pibk_pkg::OFF_ISTAT;
  wire sel_imask = paddr == pibk_pkg::OFF_IMASK;
  wire [BW-1:0] wbyte = pwdata[BW-1:0];

  logic [NE-1:0]         sel_en;
  logic [NE:0][DW-1:0]   en_rd_acc;

  assign en_rd_acc[0] = pibk_pkg::WORD_ZERO;

  genvar gi;
  generate
    for (gi = 0; gi < NE; gi++)
    begin : g_en
      localparam logic [pibk_pkg::ADDR_W-1:0] OFF =
        pibk_pkg::ADDR_W'(pibk_pkg::OFF_EN1 + gi * pibk_pkg::REG_STRIDE);
      assign sel_en[gi] = paddr == OFF;
      // Unimplemented enable bits are masked so they read as zero.
      assign en_d[gi] = (wr_en & sel_en[gi]) ?
        (wbyte & pibk_pkg::EN_IMPL[gi]) : en_q[gi];
      assign en_rd_acc[gi+1] = en_rd_acc[gi] |
        (sel_en[gi] ? {{(DW-BW){1'b0}}, en_q[gi]} : pibk_pkg::WORD_ZERO);
    end
  endgenerate

  wire mapped = sel_flag6 | (|sel_en) | sel_ctrl | sel_plo | sel_phi |
                sel_istat | sel_imask;

  wire [DW-1:0] rd_word =
      en_rd_acc[NE]
    | (sel_flag6 ? {{(DW-BW){1'b0}}, flag6_q} : pibk_pkg::WORD_ZERO)
    | (sel_ctrl  ? {{(DW-pibk_pkg::CTRL_W){1'b0}}, ctrl_q}
                 : pibk_pkg::WORD_ZERO)
    | (sel_plo   ? prio_lo_q : pibk_pkg::WORD_ZERO)
    | (sel_phi   ? {{(DW-PHW){1'b0}}, prio_hi_q} : pibk_pkg::WORD_ZERO)
    | (sel_istat ? {{(DW-BW){1'b0}}, istat_q} : pibk_pkg::WORD_ZERO)
    | (sel_imask ? {{(DW-BW){1'b0}}, imask_q} : pibk_pkg::WORD_ZERO);

  // Serial flags mirror the buffer state; the access strobe that drains
  // or fills the buffer masks the flag at once so software never sees a
  // stale one while the port updates its own state.
  wire wr_flag6 = wr_en & sel_flag6;
  assign flag6_d[pibk_pkg::FLAG6_RX4] =
    serial4_rx_full & ~serial4_rx_data_reg_rd;
  assign flag6_d[pibk_pkg::FLAG6_TX4] =
    serial4_tx_empty & ~serial4_tx_data_reg_wr;
  assign flag6_d[pibk_pkg::FLAG6_RX3] =
    serial3_rx_full & ~serial3_rx_data_reg_rd;
  assign flag6_d[pibk_pkg::FLAG6_TX3] =
    serial3_tx_empty & ~serial3_tx_data_reg_wr;
  assign flag6_d[pibk_pkg::FLAG6_UNUSED] = 1'b0;
  // A comparator event in the same cycle as a clearing write wins.
  wire [pibk_pkg::CMP_N-1:0] cmp_wdata =
    pwdata[pibk_pkg::FLAG6_CMP_LSB +: pibk_pkg::CMP_N];
  assign flag6_d[pibk_pkg::FLAG6_CMP_LSB +: pibk_pkg::CMP_N] =
    comparator_event |
    (wr_flag6 ? cmp_wdata
              : flag6_q[pibk_pkg::FLAG6_CMP_LSB +: pibk_pkg::CMP_N]);

  assign ctrl_d    = (wr_en & sel_ctrl) ?
                     pwdata[pibk_pkg::CTRL_W-1:0] : ctrl_q;
  assign prio_lo_d = (wr_en & sel_plo) ? pwdata : prio_lo_q;
  assign prio_hi_d = (wr_en & sel_phi) ? pwdata[PHW-1:0] : prio_hi_q;
  assign imask_d   = (wr_en & sel_imask) ?
                     (wbyte & pibk_pkg::FLAG6_IMPL) : imask_q;

  // Status latches each rising flag six bit; write one clears, set wins.
  wire [BW-1:0] flag6_rise = flag6_d & ~flag6_q & pibk_pkg::FLAG6_IMPL;
  wire [BW-1:0] istat_clr  = (wr_en & sel_istat) ? wbyte
                                                 : pibk_pkg::BYTE_RST;
  assign istat_d = (istat_q & ~istat_clr) | flag6_rise;

  // Each source requests when both its flag and its enable are set.
  wire [NS-1:0] src_flag = {flag6_d, ext_flags};
  wire [NS-1:0] src_en   = en_d;
  wire [NS-1:0] src_prio = {prio_hi_d, prio_lo_d};
  wire [NS-1:0] src_req  = src_flag & src_en;
  wire any_req  = |src_req;
  wire any_high = |(src_req & src_prio);
  wire any_low  = |(src_req & ~src_prio);
  wire prio_on  = ctrl_d[pibk_pkg::CTRL_PRIO_EN];
  wire group_on = ctrl_d[pibk_pkg::CTRL_GROUP_EN];
  // In legacy mode every request goes to the high line, gated by group.
  wire irq_high_d = prio_on ? any_high : (group_on & any_req);
  wire irq_low_d  = prio_on & group_on & any_low;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      flag6_q <= pibk_pkg::BYTE_RST;
      en_q    <= '0;
      ctrl_q  <= pibk_pkg::CTRL_RST;
    end
    else if (ce)
    begin
      flag6_q <= flag6_d;
      en_q    <= en_d;
      ctrl_q  <= ctrl_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prio_lo_q <= pibk_pkg::PRIO_LO_RST;
      prio_hi_q <= pibk_pkg::PRIO_HI_RST;
      istat_q   <= pibk_pkg::BYTE_RST;
      imask_q   <= pibk_pkg::BYTE_RST;
    end
    else if (ce)
    begin
      prio_lo_q <= prio_lo_d;
      prio_hi_q <= prio_hi_d;
      istat_q   <= istat_d;
      imask_q   <= imask_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_high_q <= 1'b0;
      irq_low_q  <= 1'b0;
      bank_irq_q <= 1'b0;
    end
    else if (ce)
    begin
      irq_high_q <= irq_high_d;
      irq_low_q  <= irq_low_d;
      bank_irq_q <= |(istat_d & imask_d);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= pibk_pkg::WORD_ZERO;
    end
    else if (ce)
    begin
      pready_q  <= answer;
      pslverr_q <= answer & ~mapped;
      if (answer & ~pwrite)
      begin
        prdata_q <= rd_word;
      end
    end
  end

  assign prdata        = prdata_q;
  assign pready        = pready_q;
  assign pslverr       = pslverr_q;
  assign core_irq_high = irq_high_q;
  assign core_irq_low  = irq_low_q;
  assign bank_irq      = bank_irq_q;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_setup;
    psel && !penable && ce;
  endsequence

  sequence s_access_wait;
    psel && penable && !pready_q && ce;
  endsequence

  a_rx4_follows: assert property (
    ce |=> flag6_q[pibk_pkg::FLAG6_RX4] ==
      ($past(serial4_rx_full) && !$past(serial4_rx_data_reg_rd)))
    else $error("serial4 receive flag wrong");

  a_tx4_follows: assert property (
    ce && serial4_tx_data_reg_wr |=> !flag6_q[pibk_pkg::FLAG6_TX4])
    else $error("serial4 transmit flag not cleared by write");

  a_rx3_follows: assert property (
    ce && serial3_rx_full && !serial3_rx_data_reg_rd
      |=> flag6_q[pibk_pkg::FLAG6_RX3])
    else $error("serial3 receive flag not set");

  a_tx3_follows: assert property (
    ce |=> flag6_q[pibk_pkg::FLAG6_TX3] ==
      ($past(serial3_tx_empty) && !$past(serial3_tx_data_reg_wr)))
    else $error("serial3 transmit flag wrong");

  a_bit3_zero: assert property (
    !flag6_q[pibk_pkg::FLAG6_UNUSED])
    else $error("unimplemented flag bit set");

  a_cmp_sets: assert property (
    ce && comparator_event[0] |=> flag6_q[pibk_pkg::FLAG6_CMP_LSB])
    else $error("comparator event lost");

  a_cmp_sticky: assert property (
    ce && flag6_q[pibk_pkg::FLAG6_CMP_LSB] && !(wr_en && sel_flag6)
      |=> flag6_q[pibk_pkg::FLAG6_CMP_LSB])
    else $error("comparator flag cleared without software");

  a_group_gate: assert property (
    ce && !ctrl_d[pibk_pkg::CTRL_PRIO_EN]
      && !ctrl_d[pibk_pkg::CTRL_GROUP_EN] |=> !core_irq_high && !core_irq_low)
    else $error("request passed with group disabled");

  a_enable_blocks: assert property (
    ce && en_d == '0 && ext_flags != '0 |=> !core_irq_high && !core_irq_low)
    else $error("request passed with enables clear");

  a_en_write: assert property (
    ce && wr_en && sel_en[0] |=> en_q[0] == $past(wbyte))
    else $error("enable register one write lost");

  a_high_route: assert property (
    ce && prio_on && any_high |=> core_irq_high)
    else $error("high priority request not routed");

  a_apb_answer: assert property (
    s_setup ##1 s_access_wait |=> pready && $past(pready) == 1'b0)
    else $error("bus answer not after one wait state");

  sequence s_cmp1_event;
    ce && comparator_event[0];
  endsequence

  sequence s_no_flag_write;
    ce && !(wr_en && sel_flag6);
  endsequence

  a_rx4_strobe: assert property (
    ce && serial4_rx_data_reg_rd |=> !flag6_q[pibk_pkg::FLAG6_RX4])
    else $error("serial4 receive flag not cleared by read");

  a_rx3_strobe: assert property (
    ce && serial3_rx_data_reg_rd |=> !flag6_q[pibk_pkg::FLAG6_RX3])
    else $error("serial3 receive flag not cleared by read");

  a_cmp_each_set: assert property (
    ce && comparator_event != '0 |=>
      (flag6_q[pibk_pkg::FLAG6_CMP_LSB +: pibk_pkg::CMP_N]
        & $past(comparator_event)) == $past(comparator_event))
    else $error("comparator event did not set its flag");

  a_cmp_holds: assert property (
    s_cmp1_event ##1 s_no_flag_write |=> flag6_q[pibk_pkg::FLAG6_CMP_LSB])
    else $error("comparator flag dropped without a write");

  a_cmp_write: assert property (
    ce && wr_en && sel_flag6 && comparator_event == '0 |=>
      flag6_q[pibk_pkg::FLAG6_CMP_LSB +: pibk_pkg::CMP_N] == $past(cmp_wdata))
    else $error("comparator flag write lost");

  a_en_unimpl: assert property (
    (en_q & ~pibk_pkg::EN_IMPL) == '0)
    else $error("unimplemented enable bit set");

  a_legacy_high: assert property (
    ce && !prio_on && group_on && any_req |=> core_irq_high)
    else $error("enabled request not passed in legacy mode");

  a_low_legacy: assert property (
    ce && !prio_on |=> !core_irq_low)
    else $error("low line used with priority off");

  a_low_route: assert property (
    ce && prio_on && group_on && any_low |=> core_irq_low)
    else $error("low priority request not routed");

  a_istat_rise: assert property (
    ce && !flag6_q[pibk_pkg::FLAG6_CMP_LSB] && comparator_event[0]
      |=> istat_q[pibk_pkg::FLAG6_CMP_LSB])
    else $error("status bit not set by rising flag");

  a_bank_set: assert property (
    ce && (istat_q & imask_q) != '0 && !(wr_en && (sel_istat || sel_imask))
      |=> bank_irq)
    else $error("unmasked status bit without interrupt");

  a_ready_pulse: assert property (
    ce && pready |=> !pready)
    else $error("bus answer held longer than one cycle");

  a_err_ready: assert property (
    pslverr |-> pready)
    else $error("error flag without bus answer");

  a_ce_freeze: assert property (
    !ce |=> $stable(flag6_q) && $stable(en_q) && $stable(istat_q))
    else $error("state changed while clock enable low");

endmodule // pibk_bank

// [tb/pibk_periph_model.sv]
// Model of the serial ports and comparators that feed the interrupt bank.
`timescale 1ns/1ps
module pibk_periph_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [3:0] fill_cmd,
  input  wire logic [3:0] sw_cmd,
  input  wire logic [2:0] cmp_cmd,
  output logic      [3:0] level_q,
  output logic      [3:0] strobe_q,
  output logic      [2:0] cmp_q
);
  // Bit order of level_q and strobe_q is rx4, tx4, rx3, tx3.
  // A data register access drops the level in the same cycle as its
  // strobe, so the bank never sees the strobe without the level change.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      level_q  <= 4'h0;
      strobe_q <= 4'h0;
      cmp_q    <= 3'h0;
    end
    else
    begin
      level_q  <= (level_q | fill_cmd) & ~sw_cmd;
      strobe_q <= sw_cmd;
      cmp_q    <= cmp_cmd;
    end
  end
endmodule // pibk_periph_model

// [tb/pibk_bank_tb.sv]
// Self-checking bench for the peripheral interrupt bank.
`timescale 1ns/1ps
module pibk_bank_tb;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        ce = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [39:0] ext_flags = 40'h00_0000_0000;
  logic [3:0]  fill = 4'h0;
  logic [3:0]  sw = 4'h0;
  logic [2:0]  cmp = 3'h0;
  logic [3:0]  lvl;
  logic [3:0]  stb;
  logic [2:0]  cev;
  logic        irq_hi;
  logic        irq_lo;
  logic        irq_bk;
  logic [31:0] rd;
  logic        err;
  int          n_fail = 0;
  int          n_tests = 0;
  int          cyc = 0;

  always #2 pclk = ~pclk;

  pibk_bank DUT (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_flags(ext_flags), .serial4_rx_full(lvl[3]),
    .serial4_rx_data_reg_rd(stb[3]), .serial4_tx_empty(lvl[2]),
    .serial4_tx_data_reg_wr(stb[2]), .serial3_rx_full(lvl[1]),
    .serial3_rx_data_reg_rd(stb[1]), .serial3_tx_empty(lvl[0]),
    .serial3_tx_data_reg_wr(stb[0]), .comparator_event(cev),
    .core_irq_high(irq_hi), .core_irq_low(irq_lo), .bank_irq(irq_bk));

  pibk_periph_model u_periph (.pclk(pclk), .presetn(presetn),
    .fill_cmd(fill), .sw_cmd(sw), .cmp_cmd(cmp), .level_q(lvl),
    .strobe_q(stb), .cmp_q(cev));

  task automatic end_of_test();
    $display("tests %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // The whole run needs well under a thousand cycles.
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_fail++;
      end_of_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // No wait-state count is assumed; only the bench timeout ends a hang.
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, e);
  endtask

  task automatic ev(input logic [3:0] f, input logic [3:0] s,
                    input logic [2:0] c);
    @(posedge pclk);
    fill <= f;
    sw <= s;
    cmp <= c;
    @(posedge pclk);
    fill <= 4'h0;
    sw <= 4'h0;
    cmp <= 3'h0;
    repeat (3) @(posedge pclk);
  endtask

  // Order of the expected bits is high, low, bank.
  task automatic ichk(input logic [2:0] e);
    repeat (2) @(posedge pclk);
    #1;
    chk(32'({irq_hi, irq_lo, irq_bk}), 32'(e));
  endtask

  task automatic t_regs();
    logic [7:0] a;
    rchk(pibk_pkg::OFF_FLAG6, 32'h0000_0000);
    rchk(pibk_pkg::OFF_PRIO_LO, pibk_pkg::PRIO_LO_RST);
    for (int i = 0; i < pibk_pkg::NUM_EN; i++)
    begin
      a = pibk_pkg::OFF_EN1 + 8'(4 * i);
      rchk(a, 32'h0000_0000);
      wr(a, 32'hFFFF_FFFF);
      rchk(a, 32'(pibk_pkg::EN_IMPL[i]));
      wr(a, 32'h0000_0000);
      rchk(a, 32'h0000_0000);
    end
    apb(1'b0, 8'h30, 32'h0000_0000);
    chk(32'(err), 32'h0000_0001);
    $display("test regs done");
  endtask

  task automatic t_serial();
    ev(4'hF, 4'h0, 3'h0);
    rchk(pibk_pkg::OFF_FLAG6, 32'h0000_00F0);
    // Serial flags mirror the ports, so a clearing write must not stick.
    wr(pibk_pkg::OFF_FLAG6, 32'h0000_0000);
    rchk(pibk_pkg::OFF_FLAG6, 32'h0000_00F0);
    ev(4'h0, 4'h9, 3'h0);
    rchk(pibk_pkg::OFF_FLAG6, 32'h0000_0060);
    ev(4'h0, 4'h6, 3'h0);
    rchk(pibk_pkg::OFF_FLAG6, 32'h0000_0000);
    $display("test serial done");
  endtask

  task automatic t_cmp();
    ev(4'h0, 4'h0, 3'h7);
    repeat (20) @(posedge pclk);
    rchk(pibk_pkg::OFF_FLAG6, 32'h0000_0007);
    wr(pibk_pkg::OFF_FLAG6, 32'h0000_0008);
    rchk(pibk_pkg::OFF_FLAG6, 32'h0000_0000);
    wr(pibk_pkg::OFF_FLAG6, 32'h0000_000F);
    rchk(pibk_pkg::OFF_FLAG6, 32'h0000_0007);
    wr(pibk_pkg::OFF_FLAG6, 32'h0000_0000);
    $display("test cmp done");
  endtask

  task automatic t_gate();
    ev(4'h0, 4'h0, 3'h1);
    wr(8'h18, 32'h0000_0001);
    ichk(3'b000);
    wr(pibk_pkg::OFF_CTRL, 32'h0000_0001);
    ichk(3'b100);
    wr(8'h18, 32'h0000_0000);
    ichk(3'b000);
    @(posedge pclk);
    ext_flags <= 40'h00_0000_0080;
    wr(pibk_pkg::OFF_EN1, 32'h0000_0080);
    ichk(3'b100);
    wr(pibk_pkg::OFF_EN1, 32'h0000_0000);
    ext_flags <= 40'h00_0000_0000;
    wr(8'h18, 32'h0000_0001);
    wr(pibk_pkg::OFF_CTRL, 32'h0000_0003);
    ichk(3'b100);
    wr(pibk_pkg::OFF_PRIO_HI, 32'h0000_0000);
    ichk(3'b010);
    wr(pibk_pkg::OFF_CTRL, 32'h0000_0002);
    ichk(3'b000);
    wr(8'h18, 32'h0000_0000);
    wr(pibk_pkg::OFF_FLAG6, 32'h0000_0000);
    $display("test gate done");
  endtask

  task automatic t_istat();
    wr(pibk_pkg::OFF_ISTAT, 32'h0000_00FF);
    ev(4'h0, 4'h0, 3'h2);
    rchk(pibk_pkg::OFF_ISTAT, 32'h0000_0002);
    ichk(3'b000);
    wr(pibk_pkg::OFF_IMASK, 32'h0000_0002);
    ichk(3'b001);
    wr(pibk_pkg::OFF_ISTAT, 32'h0000_0002);
    ichk(3'b000);
    rchk(pibk_pkg::OFF_ISTAT, 32'h0000_0000);
    $display("test istat done");
  endtask

  // A comparator pulse while the clock enable is low must be lost.
  task automatic t_freeze();
    @(posedge pclk);
    ce <= 1'b0;
    ev(4'h0, 4'h0, 3'h4);
    ce <= 1'b1;
    rchk(pibk_pkg::OFF_FLAG6, 32'h0000_0002);
    rchk(pibk_pkg::OFF_ISTAT, 32'h0000_0000);
    $display("test freeze done");
  endtask

  task automatic t_reset();
    wr(pibk_pkg::OFF_EN1, 32'h0000_00FF);
    wr(pibk_pkg::OFF_CTRL, 32'h0000_0001);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rchk(pibk_pkg::OFF_EN1, 32'h0000_0000);
    rchk(pibk_pkg::OFF_CTRL, 32'h0000_0000);
    rchk(pibk_pkg::OFF_FLAG6, 32'h0000_0000);
    rchk(pibk_pkg::OFF_PRIO_HI, 32'(pibk_pkg::PRIO_HI_RST));
    ichk(3'b000);
    $display("test reset done");
  endtask

  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_serial();
    t_cmp();
    t_gate();
    t_istat();
    t_freeze();
    t_reset();
    end_of_test();
  end
endmodule // pibk_bank_tb
